//--- rf_buffer_pkg.sv
// constants, register layouts and state encodings for the rf buffer status block
package rf_buffer_pkg;

    // ************************************************************
    // buffer geometry
    // ************************************************************
    localparam int unsigned FIFO_WIDTH = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned FIFO_CNT_W = 5;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFS_FILL_STATUS = 8'h0C;
    localparam logic [7:0] OFS_FLAG_STATUS = 8'h0D;
    localparam logic [7:0] OFS_LAST_LOC    = 8'h0E;

    // ************************************************************
    // reset and special values
    // ************************************************************
    localparam logic [7:0] FILL_RESET   = 8'h00;
    localparam logic [7:0] FLAG_RESET   = 8'h00;
    localparam logic [7:0] LOC_RESET    = 8'h00;
    localparam logic [7:0] LOC_UPDATING = 8'hFF;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;

    // ************************************************************
    // register layouts
    // ************************************************************
    typedef struct packed {
        logic       len_unstable;
        logic       rsvd6;
        logic [5:0] pending;
    } fill_status_t;

    typedef struct packed {
        logic [1:0] rsvd76;
        logic       radio_side_busy;
        logic       radio_data_ready;
        logic       host_data_ready;
        logic       rsvd2;
        logic       underflow;
        logic       overflow;
    } flag_status_t;

    // ************************************************************
    // last-location update sequence
    // ************************************************************
    typedef enum logic [1:0] {
        LOC_IDLE = 2'b00,
        LOC_MARK = 2'b01
    } loc_state_t;

endpackage : rf_buffer_pkg

//--- cdc_sync2.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module cdc_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    // level in, synchronised level out
    input  wire logic [WIDTH-1:0] d_in,
    output logic      [WIDTH-1:0] q_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta_q <= '0;
            q_out  <= '0;
        end
        else
        begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end

endmodule : cdc_sync2
`default_nettype wire

//--- byte_fifo.sv
// synchronous fifo in flip-flops with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned CNT_W = 5
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             nrst_in,
    input  wire logic             flush_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out,
    // level
    output logic      [CNT_W-1:0] count_out
);

    localparam int unsigned PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready_out  = (cnt_q != CNT_W'(DEPTH));
    assign out_valid_out = (cnt_q != '0);
    assign out_data_out  = mem_q[rd_q];
    assign count_out     = cnt_q;

    always_comb
    begin
        push = in_valid_in && in_ready_out && !flush_in;
        pop  = out_ready_in && out_valid_out && !flush_in;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (flush_in)
        begin
            wr_d  = '0;
            rd_d  = '0;
            cnt_d = '0;
        end
        else
        begin
            if (push)
                wr_d = PTR_W'(wr_q + 1'b1);
            if (pop)
                rd_d = PTR_W'(rd_q + 1'b1);
            if (push && !pop)
                cnt_d = CNT_W'(cnt_q + 1'b1);
            else if (pop && !push)
                cnt_d = CNT_W'(cnt_q - 1'b1);
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // storage needs no reset; only written slots are ever read
    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_q[wr_q] <= in_data_in;
    end

endmodule : byte_fifo
`default_nettype wire

//--- rf_buffer_status_last_address.sv
// buffer status, handshake flags and last rf location for the reader data buffer
// Function
// [RL1] length-unstable flag bit 7 of fill status high while buffer contents change
// [RL2] fill status bits 5:0 count received bytes not yet read by host
// [RL3] pending count of zero means no received bytes remain to read
// [RL4] fill status clears on power-up, restore-defaults, flush and idle/halt
// [RL5] underflow flag bit 1 set when host reads more than buffer holds
// [RL6] overflow flag bit 0 set when more bytes arrive than buffer holds
// [RL7] flag status shows radio busy bit 5, radio ready 4, host ready 3
// [RL8] host-side busy flag is never shown in flag status
// [RL9] 8-bit record of last location the reader accessed over rf
// [RL10] record also captures accesses beyond implemented memory space
// [RL11] record reads FFh while updating; host treats it as invalid
// [RL12] record clears on power-up, restore-defaults and flush commands; a command in the cycle of an access edge or in LOC_MARK is ignored
// [RL13] buffer fault interrupt raised whenever overflow or underflow is flagged
// [RL14] reserved bits of buffer status registers read as zero
`timescale 1ns/1ps
`default_nettype none
module rf_buffer_status_last_address (
    // main clock and reset
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    // link side, on link clock
    input  wire logic       link_clk_in,
    input  wire logic       link_byte_valid_in,
    input  wire logic [7:0] link_byte_in,
    input  wire logic       link_frame_active_in,
    input  wire logic       link_access_in,
    input  wire logic [7:0] link_access_addr_in,
    output logic            link_byte_busy_out,
    // host register read port
    input  wire logic       host_read_in,
    input  wire logic [7:0] host_addr_in,
    output logic      [7:0] host_rdata_out,
    output logic            host_rvalid_out,
    // host buffer drain port
    input  wire logic       host_pop_in,
    output logic      [7:0] host_pop_data_out,
    output logic            host_pop_valid_out,
    input  wire logic       host_data_ready_in,
    // commands
    input  wire logic       restore_defaults_cmd_in,
    input  wire logic       flush_buffer_cmd_in,
    input  wire logic       idle_halt_cmd_in,
    // fault indication
    output logic            buffer_fault_irq_out
);

    // ************************************************************
    // link domain: toggle handshakes toward the main domain
    // ************************************************************
    logic       lk_req_q, lk_req_d;
    logic       lk_ovr_q, lk_ovr_d;
    logic       lk_acc_q, lk_acc_d;
    logic [7:0] lk_data_q, lk_data_d;
    logic [7:0] lk_addr_q, lk_addr_d;
    logic       lk_busy_q, lk_busy_d;
    logic       lk_ack_s;
    logic       ack_q, ack_d;

    cdc_sync2 #(.WIDTH(1)) u_ack_sync (
        .clk_in  (link_clk_in),
        .nrst_in (nrst_in),
        .d_in    (ack_q),
        .q_out   (lk_ack_s)
    );

    always_comb
    begin
        lk_req_d  = lk_req_q;
        lk_ovr_d  = lk_ovr_q;
        lk_acc_d  = lk_acc_q;
        lk_data_d = lk_data_q;
        lk_addr_d = lk_addr_q;
        if (link_byte_valid_in)
        begin
            // a byte while the previous one is still in flight has no room
            if (lk_req_q != lk_ack_s)
                lk_ovr_d = ~lk_ovr_q; // see [RL6]
            else
            begin
                lk_req_d  = ~lk_req_q;
                lk_data_d = link_byte_in;
            end
        end
        if (link_access_in)
        begin
            lk_acc_d  = ~lk_acc_q;
            lk_addr_d = link_access_addr_in; // see [RL10]
        end
        lk_busy_d = (lk_req_d != lk_ack_s);
    end

    always_ff @(posedge link_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            lk_req_q  <= 1'b0;
            lk_ovr_q  <= 1'b0;
            lk_acc_q  <= 1'b0;
            lk_data_q <= 8'h00;
            lk_addr_q <= 8'h00;
            lk_busy_q <= 1'b0;
        end
        else
        begin
            lk_req_q  <= lk_req_d;
            lk_ovr_q  <= lk_ovr_d;
            lk_acc_q  <= lk_acc_d;
            lk_data_q <= lk_data_d;
            lk_addr_q <= lk_addr_d;
            lk_busy_q <= lk_busy_d;
        end
    end

    assign link_byte_busy_out = lk_busy_q;

    // ************************************************************
    // main domain: crossings and buffer
    // ************************************************************
    logic [3:0] sync_s;
    logic       req_s, ovr_s, acc_s, frame_s;
    logic       ovr_p_q, acc_p_q;
    logic       ovr_edge, acc_edge, pending;
    logic       clear_all, clear_loc;
    logic       fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [rf_buffer_pkg::FIFO_CNT_W-1:0] fifo_count;
    logic       push_fire, pop_fire, pop_empty;

    cdc_sync2 #(.WIDTH(4)) u_link_sync (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    ({lk_req_q, lk_ovr_q, lk_acc_q, link_frame_active_in}),
        .q_out   (sync_s)
    );

    assign req_s     = sync_s[3];
    assign ovr_s     = sync_s[2];
    assign acc_s     = sync_s[1];
    assign frame_s   = sync_s[0];
    assign ovr_edge  = (ovr_s != ovr_p_q);
    assign acc_edge  = (acc_s != acc_p_q);
    assign pending   = (req_s != ack_q);
    assign clear_all = restore_defaults_cmd_in || flush_buffer_cmd_in || idle_halt_cmd_in;
    assign clear_loc = restore_defaults_cmd_in || flush_buffer_cmd_in;
    assign push_fire = pending && fifo_in_ready && !clear_all;
    assign pop_fire  = host_pop_in && fifo_out_valid && !clear_all;
    assign pop_empty = host_pop_in && !fifo_out_valid;

    // link data is held until acknowledged, so it is stable when pushed
    byte_fifo #(
        .WIDTH (rf_buffer_pkg::FIFO_WIDTH),
        .DEPTH (rf_buffer_pkg::FIFO_DEPTH),
        .CNT_W (rf_buffer_pkg::FIFO_CNT_W)
    ) u_fifo (
        .clk_in        (clk_in),
        .nrst_in       (nrst_in),
        .flush_in      (clear_all),
        .in_valid_in   (pending),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (lk_data_q),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (host_pop_in),
        .out_data_out  (fifo_out_data),
        .count_out     (fifo_count)
    );

    // ************************************************************
    // status registers
    // ************************************************************
    rf_buffer_pkg::fill_status_t fill_q, fill_d;
    rf_buffer_pkg::flag_status_t flag_q, flag_d;
    logic       irq_q, irq_d;
    logic [7:0] pop_data_q, pop_data_d;
    logic       pop_valid_q, pop_valid_d;

    always_comb
    begin
        // a full fifo withholds the ack, which stalls the link source
        ack_d = (pending && (fifo_in_ready || clear_all)) ? ~ack_q : ack_q;
        fill_d = rf_buffer_pkg::FILL_RESET;
        if (!clear_all) // see [RL4]
        begin
            fill_d.len_unstable = push_fire || pop_fire || pending; // see [RL1]
            fill_d.pending      = {1'b0, fifo_count}; // see [RL2] [RL3]
        end
        fill_d.rsvd6 = 1'b0; // see [RL14]
        flag_d = rf_buffer_pkg::FLAG_RESET;
        // set wins over a clear arriving in the same cycle
        flag_d.overflow  = (flag_q.overflow && !clear_all) || ovr_edge; // see [RL6]
        flag_d.underflow = (flag_q.underflow && !clear_all) || pop_empty; // see [RL5]
        flag_d.radio_side_busy  = frame_s || pending; // see [RL7]
        flag_d.radio_data_ready = fifo_out_valid; // see [RL7]
        flag_d.host_data_ready  = host_data_ready_in; // see [RL7]
        flag_d.rsvd76 = 2'b00; // see [RL8] [RL14]
        flag_d.rsvd2  = 1'b0;
        irq_d = flag_d.overflow || flag_d.underflow; // see [RL13]
        pop_valid_d = pop_fire;
        pop_data_d  = pop_fire ? fifo_out_data : pop_data_q;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            ack_q       <= 1'b0;
            ovr_p_q     <= 1'b0;
            acc_p_q     <= 1'b0;
            fill_q      <= rf_buffer_pkg::FILL_RESET;
            flag_q      <= rf_buffer_pkg::FLAG_RESET;
            irq_q       <= 1'b0;
            pop_data_q  <= 8'h00;
            pop_valid_q <= 1'b0;
        end
        else
        begin
            ack_q       <= ack_d;
            ovr_p_q     <= ovr_s;
            acc_p_q     <= acc_s;
            fill_q      <= fill_d;
            flag_q      <= flag_d;
            irq_q       <= irq_d;
            pop_data_q  <= pop_data_d;
            pop_valid_q <= pop_valid_d;
        end
    end

    assign buffer_fault_irq_out = irq_q;
    assign host_pop_data_out    = pop_data_q;
    assign host_pop_valid_out   = pop_valid_q;

    // ************************************************************
    // last rf location
    // ************************************************************
    rf_buffer_pkg::loc_state_t loc_st_q, loc_st_d;
    logic [7:0] loc_q, loc_d;

    // limitation: accesses closer than the crossing latency may tear the address
    always_comb
    begin
        loc_st_d = loc_st_q;
        loc_d    = loc_q;
        case (loc_st_q)
            rf_buffer_pkg::LOC_IDLE:
            begin
                if (acc_edge)
                begin
                    loc_st_d = rf_buffer_pkg::LOC_MARK;
                    loc_d    = rf_buffer_pkg::LOC_UPDATING; // see [RL11]
                end
                else if (clear_loc)
                    loc_d = rf_buffer_pkg::LOC_RESET; // see [RL12]
            end
            rf_buffer_pkg::LOC_MARK:
            begin
                loc_st_d = rf_buffer_pkg::LOC_IDLE;
                loc_d    = lk_addr_q; // see [RL9]
            end
            default:
            begin
                loc_st_d = rf_buffer_pkg::LOC_IDLE;
                loc_d    = rf_buffer_pkg::LOC_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            loc_st_q <= rf_buffer_pkg::LOC_IDLE;
            loc_q    <= rf_buffer_pkg::LOC_RESET;
        end
        else
        begin
            loc_st_q <= loc_st_d;
            loc_q    <= loc_d;
        end
    end

    // ************************************************************
    // host read port
    // ************************************************************
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q;

    always_comb
    begin
        case (host_addr_in)
            rf_buffer_pkg::OFS_FILL_STATUS: rdata_d = fill_q;
            rf_buffer_pkg::OFS_FLAG_STATUS: rdata_d = flag_q;
            rf_buffer_pkg::OFS_LAST_LOC:    rdata_d = loc_q;
            default:                        rdata_d = rf_buffer_pkg::UNMAPPED_VAL;
        endcase
        if (!host_read_in)
            rdata_d = rdata_q;
    end

    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q  <= rdata_d;
            rvalid_q <= host_read_in;
        end
    end

    assign host_rdata_out  = rdata_q;
    assign host_rvalid_out = rvalid_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    a_unstable_on_change: assert property ((push_fire || pop_fire) |=> fill_q.len_unstable) // see [RL1]
        else $error("length-unstable flag missing during buffer change");
    a_pending_count: assert property (!$past(clear_all) |-> fill_q.pending == {1'b0, $past(fifo_count)}) // see [RL2]
        else $error("pending count differs from buffer level");
    a_zero_means_empty: assert property ((fill_q.pending == 6'h00 && !$past(clear_all)) |-> !$past(fifo_out_valid)) // see [RL3]
        else $error("zero count while bytes remain");
    a_clear_fill: assert property (clear_all |=> fill_q == rf_buffer_pkg::FILL_RESET) // see [RL4]
        else $error("fill status not cleared by command");
    a_underflow_set: assert property (pop_empty |=> flag_q.underflow ##1 (flag_q.underflow || $past(clear_all))) // see [RL5]
        else $error("underflow not flagged");
    a_overflow_set: assert property (ovr_edge |=> flag_q.overflow) // see [RL6]
        else $error("overflow not flagged");
    a_ready_flags: assert property (flag_q.radio_data_ready == $past(fifo_out_valid) && flag_q.host_data_ready == $past(host_data_ready_in)) // see [RL7]
        else $error("handshake flags wrong");
    a_reserved_zero: assert property (flag_q.rsvd76 == 2'b00 && !flag_q.rsvd2 && !fill_q.rsvd6) // see [RL8]
        else $error("reserved status bit set");
    a_loc_updating: assert property ((acc_edge && loc_st_q == rf_buffer_pkg::LOC_IDLE) |=> loc_q == 8'hFF ##1 loc_q == $past(lk_addr_q)) // see [RL11]
        else $error("last location update sequence wrong");
    a_loc_clear: assert property ((clear_loc && !acc_edge && loc_st_q == rf_buffer_pkg::LOC_IDLE) |=> loc_q == 8'h00) // see [RL12]
        else $error("last location not cleared");
    a_fault_irq: assert property (buffer_fault_irq_out == (flag_q.overflow || flag_q.underflow)) // see [RL13]
        else $error("fault interrupt disagrees with flags");

    c_fifo_full: cover property (fifo_count == 5'h10);
    c_overflow: cover property (flag_q.overflow);
    c_underflow: cover property (flag_q.underflow);
    c_loc_update: cover property (loc_st_q == rf_buffer_pkg::LOC_MARK ##1 loc_q != 8'hFF);

endmodule : rf_buffer_status_last_address
`default_nettype wire

//--- link_reader_model.sv
// link-side reader model: offers bytes and memory accesses on the link clock
`timescale 1ns/1ps
`default_nettype none
module link_reader_model (
    // link clock and back-pressure
    input  wire logic       link_clk_in,
    input  wire logic       busy_in,
    // byte and access outputs
    output logic            byte_valid_out,
    output logic [7:0]      byte_out,
    output logic            access_out,
    output logic [7:0]      access_addr_out
);
    initial
    begin
        byte_valid_out  = 1'b0;
        byte_out        = 8'h00;
        access_out      = 1'b0;
        access_addr_out = 8'h00;
    end

    // ignore_busy offers the byte at once, to provoke a dropped byte
    task automatic send(input logic [7:0] b, input bit ignore_busy, output bit ok);
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++)
        begin
            @(posedge link_clk_in);
            ok = ignore_busy || !busy_in;
        end
        byte_valid_out <= 1'b1;
        byte_out       <= b;
        @(posedge link_clk_in);
        byte_valid_out <= 1'b0;
        // released lines show the inverse so a stale byte cannot pass
        byte_out       <= ~b;
    endtask : send

    task automatic access(input logic [7:0] ad);
        @(posedge link_clk_in);
        access_out      <= 1'b1;
        access_addr_out <= ad;
        @(posedge link_clk_in);
        access_out      <= 1'b0;
        access_addr_out <= ~ad;
    endtask : access
endmodule : link_reader_model
`default_nettype wire

//--- rf_buffer_status_last_address_tb.sv
// self-checking bench for the rf buffer status block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rf_buffer_status_last_address_tb;
    typedef struct packed { logic [7:0] mask; logic [7:0] val; } note_t;
    localparam logic [7:0] FILL = rf_buffer_pkg::OFS_FILL_STATUS;
    localparam logic [7:0] FLAG = rf_buffer_pkg::OFS_FLAG_STATUS;
    localparam logic [7:0] LOC  = rf_buffer_pkg::OFS_LAST_LOC;
    logic       clk_in = 1'b0, nrst_in = 1'b0, link_clk = 1'b0, frame = 1'b0;
    logic       host_read = 1'b0, pop = 1'b0, host_rdy = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [2:0] cmd = 3'b000;
    logic       lvalid, laccess, busy, rvalid, pvalid, irq;
    logic [7:0] lbyte, laddr, rdata, pdata, a, last;
    note_t      q[$];
    note_t      e;
    logic [7:0] bq[$];
    int         err_total = 0, tests_run = 0, ff_n = 0;
    bit         snoop = 1'b0, ok;

    rf_buffer_status_last_address dut (
        .clk_in(clk_in), .nrst_in(nrst_in), .link_clk_in(link_clk),
        .link_byte_valid_in(lvalid), .link_byte_in(lbyte),
        .link_frame_active_in(frame), .link_access_in(laccess),
        .link_access_addr_in(laddr), .link_byte_busy_out(busy),
        .host_read_in(host_read), .host_addr_in(addr), .host_rdata_out(rdata),
        .host_rvalid_out(rvalid), .host_pop_in(pop), .host_pop_data_out(pdata),
        .host_pop_valid_out(pvalid), .host_data_ready_in(host_rdy),
        .restore_defaults_cmd_in(cmd[0]), .flush_buffer_cmd_in(cmd[1]),
        .idle_halt_cmd_in(cmd[2]), .buffer_fault_irq_out(irq));
    link_reader_model reader (
        .link_clk_in(link_clk), .busy_in(busy), .byte_valid_out(lvalid),
        .byte_out(lbyte), .access_out(laccess), .access_addr_out(laddr));

    initial forever #5 clk_in = ~clk_in;
    // link clock stands still outside frames, but runs through reset
    initial
    begin
        #3;
        forever #16 if (frame || !nrst_in) link_clk = ~link_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic rd(input logic [7:0] ad, input logic [7:0] ex,
                      input logic [7:0] m = 8'hFF);
        @(posedge clk_in);
        host_read <= 1'b1;
        addr      <= ad;
        q.push_back('{m, ex});
        @(posedge clk_in);
        host_read <= 1'b0;
    endtask : rd
    task automatic pop_one(input bit has);
        @(posedge clk_in);
        pop <= 1'b1;
        if (has) q.push_back('{8'hFF, bq.pop_front()});
        @(posedge clk_in);
        pop <= 1'b0;
    endtask : pop_one
    task automatic issue(input logic [2:0] c);
        @(posedge clk_in);
        cmd <= c;
        @(posedge clk_in);
        cmd <= 3'b000;
    endtask : issue
    function automatic logic [7:0] fl(input logic [7:0] x);
        return x | 8'h20 | {4'h0, host_rdy, 3'b000};
    endfunction : fl
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    always @(posedge clk_in)
        if (rvalid && snoop)
        begin
            ff_n += (rdata === 8'hFF);
            last = rdata;
        end
        else if ((rvalid || pvalid) && q.size() == 0)
            `CHK(1'b1, 1'b0)
        else if (rvalid || pvalid)
        begin
            e = q.pop_front();
            `CHK((rvalid ? rdata : pdata) & e.mask, e.val)
        end

    initial
    begin
        #500us;
        err_total++;
        print_verdict();
    end

    initial
    begin
        void'($urandom(32'h30f21fae));
        tick(12);
        nrst_in <= 1'b1;
        tick(1);
        rd(FILL, 8'h00);
        rd(FLAG, 8'h00);
        rd(LOC, 8'h00);
        rd(8'h5A, 8'h00);
        $display("test reset done");
        frame    <= 1'b1;
        host_rdy <= 1'($urandom());
        tick(8);
        for (int i = 0; i < 3; i++)
        begin
            bq.push_back(8'($urandom()));
            reader.send(bq[i], 1'b0, ok);
            `CHK(ok, 1'b1)
        end
        tick(12);
        rd(FILL, 8'h03);
        rd(FLAG, fl(8'h10));
        `CHK(irq, 1'b0)
        // the unstable bit lasts one cycle after a pop, so read right behind it
        fork
            pop_one(1'b1);
            begin
                tick(1);
                rd(FILL, 8'h80, 8'h80);
            end
        join
        pop_one(1'b1);
        pop_one(1'b1);
        tick(4);
        rd(FILL, 8'h00);
        rd(FLAG, fl(8'h00));
        $display("test fill and drain done");
        pop_one(1'b0);
        tick(3);
        rd(FLAG, fl(8'h02));
        `CHK(irq, 1'b1)
        issue(3'b010);
        tick(2);
        rd(FLAG, fl(8'h00));
        reader.send(8'hA5, 1'b1, ok);
        reader.send(8'h5A, 1'b1, ok);
        tick(12);
        rd(FLAG, fl(8'h11));
        `CHK(irq, 1'b1)
        issue(3'b001);
        tick(2);
        rd(FLAG, fl(8'h00));
        rd(FILL, 8'h00);
        $display("test underflow and overflow done");
        for (int i = 0; i < 16; i++)
        begin
            reader.send(8'($urandom()), 1'b0, ok);
            `CHK(ok, 1'b1)
        end
        tick(12);
        rd(FILL, 8'h10);
        reader.send(8'hC3, 1'b0, ok);
        repeat (10) @(posedge link_clk);
        `CHK(busy, 1'b1)
        rd(FILL, 8'h90);
        issue(3'b100);
        tick(12);
        rd(FILL, 8'h00);
        $display("test full buffer done");
        // bit 0 held low so the address can never look like the updating mark
        a = 8'hC0 | {2'b00, 5'($urandom()), 1'b0};
        tick(2);
        snoop = 1'b1;
        host_read <= 1'b1;
        addr      <= LOC;
        reader.access(a);
        tick(16);
        host_read <= 1'b0;
        tick(2);
        snoop = 1'b0;
        `CHK(ff_n, 1)
        `CHK(last, a)
        issue(3'b100);
        tick(2);
        rd(LOC, a);
        issue(3'b010);
        tick(2);
        rd(LOC, 8'h00);
        tick(4);
        `CHK(q.size(), 0)
        $display("test last location done");
        print_verdict();
    end
endmodule : rf_buffer_status_last_address_tb
`default_nettype wire
